// file: src/ack_index_unit.sv
// inbound, awaited and outbound acknowledge index keeping
`timescale 1ns/10ps
`default_nettype none
module ack_index_unit
#(
  parameter bit ENABLE = 1'b1                        // software recovery present
)(
  input  wire logic                   ref_clk_i,
  input  wire logic                   sys_rst_i,
  input  wire logic                   clk_en_i,
  reg_req_if.user                     req,
  input  wire logic                   rx_pkt_acked_i,   // received packet acknowledged
  input  wire logic                   tx_pkt_sent_i,    // packet handed to the link
  input  wire logic                   pa_rx_i,          // packet-accepted received
  output var  rio_csr_pkg::ack_index_t rx_expected_o,
  output var  rio_csr_pkg::ack_index_t tx_awaited_o,
  output var  rio_csr_pkg::ack_index_t tx_next_o,
  output var  logic                   flush_acks_o,
  output var  logic                   retransmit_o
);
  import rio_csr_pkg::*;

  logic idx_wr;   // write to the index register
  logic do_flush; // write carries the flush bit

  assign idx_wr   = ENABLE & req.wr_stb & (req.addr == OFS_ACK_INDEX);
  assign do_flush = idx_wr & req.wdata[FLUSH_BIT];

  // ***********************************************
  // inbound index
  // ***********************************************
  // a software write wins over a same-cycle hardware step
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
      rx_expected_o <= ACK_INDEX_RST;
    else if (clk_en_i)
    begin
      if (idx_wr & ~do_flush)
        rx_expected_o <= req.wdata[RX_IDX_LSB +: IDX_W];
      else if (rx_pkt_acked_i)
        rx_expected_o <= rx_expected_o + 6'h01;
    end
  end

  // ***********************************************
  // outbound and awaited indices
  // ***********************************************
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      tx_next_o    <= ACK_INDEX_RST;
      tx_awaited_o <= ACK_INDEX_RST;
    end
    else if (clk_en_i)
    begin
      if (idx_wr)
        tx_next_o <= req.wdata[TX_IDX_LSB +: IDX_W];
      else if (tx_pkt_sent_i)
        tx_next_o <= tx_next_o + 6'h01;
      if (pa_rx_i)
        tx_awaited_o <= tx_awaited_o + 6'h01;
    end
  end

  // ***********************************************
  // one-cycle commands toward the link logic
  // ***********************************************
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      flush_acks_o <= 1'b0;
      retransmit_o <= 1'b0;
    end
    else if (clk_en_i)
    begin
      flush_acks_o <= do_flush;
      retransmit_o <= idx_wr;
    end
  end

endmodule // ack_index_unit
`default_nettype wire

// file: src/apb_access_port.sv
// apb slave handshake producing register strobes
`timescale 1ns/10ps
`default_nettype none
module apb_access_port
(
  input  wire logic                           ref_clk_i,
  input  wire logic                           sys_rst_i,
  input  wire logic                           clk_en_i,
  input  wire logic                           psel_i,
  input  wire logic                           penable_i,
  input  wire logic                           pwrite_i,
  input  wire logic [rio_csr_pkg::ADDR_W-1:0] paddr_i,
  input  wire logic [rio_csr_pkg::DATA_W-1:0] pwdata_i,
  output var  logic                           pready_o,
  reg_req_if.port                             req
);
  import rio_csr_pkg::*;

  // ***********************************************
  // strobes
  // ***********************************************
  // one wait state: the first access cycle captures, the second completes
  assign req.acc_stb  = clk_en_i & psel_i & penable_i & ~pready_o;
  assign req.wr_stb   = clk_en_i & psel_i & penable_i & pready_o & pwrite_i;
  assign req.is_write = pwrite_i;
  assign req.addr     = paddr_i;
  assign req.wdata    = pwdata_i;

  // ***********************************************
  // ready
  // ***********************************************
  // high for exactly one cycle per access, back to back allowed
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
      pready_o <= 1'b0;
    else if (clk_en_i)
      pready_o <= psel_i & penable_i & ~pready_o;
  end

endmodule // apb_access_port
`default_nettype wire

// file: src/reg_req_if.sv
// register request carrier between the bus port and the register logic
`timescale 1ns/10ps
`default_nettype none
interface reg_req_if;
  logic                              acc_stb;  // capture edge of an access
  logic                              wr_stb;   // edge at which a write takes effect
  logic                              is_write; // direction of the access
  logic [rio_csr_pkg::ADDR_W-1:0]    addr;     // byte address
  logic [rio_csr_pkg::DATA_W-1:0]    wdata;    // write data

  // bus side drives, register side listens
  modport port (output acc_stb, wr_stb, is_write, addr, wdata);
  modport user (input acc_stb, wr_stb, is_write, addr, wdata);
endinterface
`default_nettype wire

// file: src/rio_csr_pkg.sv
// shared constants and types for the error recovery register bank
`default_nettype none
package rio_csr_pkg;

  // ***********************************************
  // bus geometry
  // ***********************************************
  localparam int ADDR_W = 8;                        // byte address inside the block
  localparam int DATA_W = 32;                       // apb data width

  // ***********************************************
  // register offsets, byte addresses in the block
  // ***********************************************
  localparam logic [7:0] OFS_LINK_REQUEST = 8'h40;  // link request command
  localparam logic [7:0] OFS_REPLY        = 8'h44;  // link_reply_capture
  localparam logic [7:0] OFS_ACK_INDEX    = 8'h48;  // local_ack_index
  localparam logic [7:0] OFS_ERR_STATUS   = 8'h58;  // port_error_and_status

  // ***********************************************
  // field positions
  // ***********************************************
  localparam int REPLY_VALID_BIT = 31;              // reply captured / request sent
  localparam int REPLY_ACK_LSB   = 5;               // reply_ack_index [10:5]
  localparam int REPLY_PORT_LSB  = 0;               // port status [4:0]
  localparam int FLUSH_BIT       = 31;              // flush_pending_acks
  localparam int RX_IDX_LSB      = 24;              // rx_expected_index [29:24]
  localparam int AWAIT_IDX_LSB   = 8;               // tx_awaited_ack_index [13:8]
  localparam int TX_IDX_LSB      = 0;               // tx_next_index [5:0]
  localparam int IDLE2_SUP_BIT   = 31;              // second idle supported
  localparam int IDLE2_EN_BIT    = 30;              // second idle selected
  localparam int IDLE_ACT_BIT    = 29;              // idle sequence in use
  localparam int FLOW_MODE_BIT   = 27;              // flow control mode
  localparam int RETRY_ENC_BIT   = 20;              // output retry encountered
  localparam int RETRIED_BIT     = 19;              // output retried
  localparam int CMD_W           = 3;               // link request command width
  localparam int IDX_W           = 6;               // ack index width
  localparam int PSTAT_W         = 5;               // port status width

  // ***********************************************
  // values after reset and codes
  // ***********************************************
  localparam logic [5:0]  ACK_INDEX_RST = 6'h00;    // all three indices
  localparam logic [4:0]  PSTAT_RST     = 5'h00;    // captured port status
  localparam logic [2:0]  CMD_RST       = 3'h0;     // link request command
  localparam logic [2:0]  CMD_NO_REPLY  = 3'h3;     // command that draws no response
  localparam logic [31:0] RDATA_RST     = 32'h0000_0000;

  typedef logic [IDX_W-1:0] ack_index_t;            // one acknowledge index

endpackage
`default_nettype wire

// file: src/rio_error_recovery_csrs.sv
// error recovery status and control registers of a serial port, apb slave
// Function
// - reply and index registers only with recovery
// - reply valid sets on response, read clears
// - no-response command sets valid when sent
// - capture ack and port status, read-only
// - flush bit always reads zero
// - flush write discards unacknowledged received packets
// - inbound expected index, writable, resets zero
// - inbound index ignores write with flush set
// - awaited ack index reads back, read-only
// - outbound next index, writable, resets zero
// - outbound index write triggers retransmission
// - bit 31 reports second idle support
// - bit 30 selects idle, fixed if unsupported
// - bit 29 reports active idle sequence
// - bit 27 reports flow control mode
// - retry encountered latches, write one clears
// - command write sends link request
// - retried sets on retry, clears on accept
//
// Chosen here: register access over APB.
`timescale 1ns/10ps
`default_nettype none
module rio_error_recovery_csrs
#(
  parameter bit SW_RECOVERY   = 1'b1,  // software assisted recovery built in
  parameter bit IDLE2_SUPPORT = 1'b1,  // second idle sequence available
  parameter bit HIGH_RATE     = 1'b0,  // lane rate above 5.5 Gbaud
  parameter bit IDLE2_EN_RST  = 1'b0   // idle selection after reset
)(
  input  wire logic                           ref_clk_i,
  input  wire logic                           sys_rst_i,
  input  wire logic                           clk_en_i,
  input  wire logic                           psel_i,
  input  wire logic                           penable_i,
  input  wire logic                           pwrite_i,
  input  wire logic [rio_csr_pkg::ADDR_W-1:0] paddr_i,
  input  wire logic [rio_csr_pkg::DATA_W-1:0] pwdata_i,
  output var  logic [rio_csr_pkg::DATA_W-1:0] prdata_o,
  output var  logic                           pready_o,
  output var  logic                           pslverr_o,
  input  wire logic                           lresp_valid_i,
  input  wire logic [rio_csr_pkg::IDX_W-1:0]  lresp_ack_i,
  input  wire logic [rio_csr_pkg::PSTAT_W-1:0] lresp_port_i,
  input  wire logic                           lreq_sent_i,
  input  wire logic                           rx_pkt_acked_i,
  input  wire logic                           tx_pkt_sent_i,
  input  wire logic                           pa_rx_i,
  input  wire logic                           pna_rx_i,
  input  wire logic                           retry_rx_i,
  input  wire logic                           idle2_active_i,
  input  wire logic                           tx_flow_ctrl_i,
  output var  logic [rio_csr_pkg::CMD_W-1:0]  lreq_cmd_o,
  output var  logic                           lreq_go_o,
  output var  logic                           flush_acks_o,
  output var  logic                           retransmit_o,
  output var  rio_csr_pkg::ack_index_t        rx_expected_o,
  output var  rio_csr_pkg::ack_index_t        tx_awaited_o,
  output var  rio_csr_pkg::ack_index_t        tx_next_o,
  output var  logic                           idle2_enable_o
);
  import rio_csr_pkg::*;

  // ***********************************************
  // declarations
  // ***********************************************
  reg_req_if req ();                        // strobes from the bus port

  logic               reply_valid;          // reply bit 31
  logic [IDX_W-1:0]   reply_ack_index;      // captured ack status
  logic [PSTAT_W-1:0] reply_port;           // captured port status
  logic               retry_enc;            // output retry encountered
  logic               retried;              // last answer was a retry
  logic [DATA_W-1:0]  next_rdata;           // read mux result
  logic               reply_set;            // event that validates the reply
  logic               reply_rd;             // read of the reply register
  logic               lreq_wr;              // write to the command register
  logic               stat_wr;              // write to error and status
  logic               idle2_writable;       // selection is not frozen

  // ***********************************************
  // decode helper
  // ***********************************************
  // unaligned or unknown offsets answer with an error, read as zero
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    logic hit;
    hit = (a == OFS_ERR_STATUS);
    if (SW_RECOVERY)
      hit = hit | (a == OFS_LINK_REQUEST) | (a == OFS_REPLY) | (a == OFS_ACK_INDEX);
    return hit;
  endfunction

  // ***********************************************
  // sub-blocks
  // ***********************************************
  // bus handshake, one wait state per access
  apb_access_port u_apb
  (
    .ref_clk_i (ref_clk_i),
    .sys_rst_i (sys_rst_i),
    .clk_en_i  (clk_en_i),
    .psel_i    (psel_i),
    .penable_i (penable_i),
    .pwrite_i  (pwrite_i),
    .paddr_i   (paddr_i),
    .pwdata_i  (pwdata_i),
    .pready_o  (pready_o),
    .req       (req.port)
  );

  // acknowledge indices and their commands
  ack_index_unit #(.ENABLE(SW_RECOVERY)) u_ack
  (
    .ref_clk_i      (ref_clk_i),
    .sys_rst_i      (sys_rst_i),
    .clk_en_i       (clk_en_i),
    .req            (req.user),
    .rx_pkt_acked_i (rx_pkt_acked_i),
    .tx_pkt_sent_i  (tx_pkt_sent_i),
    .pa_rx_i        (pa_rx_i),
    .rx_expected_o  (rx_expected_o),
    .tx_awaited_o   (tx_awaited_o),
    .tx_next_o      (tx_next_o),
    .flush_acks_o   (flush_acks_o),
    .retransmit_o   (retransmit_o)
  );

  // ***********************************************
  // strobe decode
  // ***********************************************
  // the read clear rides on the capture edge so a reply that lands
  // between capture and completion is never wiped unseen
  assign reply_rd  = SW_RECOVERY & req.acc_stb & ~req.is_write & (req.addr == OFS_REPLY);
  assign lreq_wr   = SW_RECOVERY & req.wr_stb & (req.addr == OFS_LINK_REQUEST);
  assign stat_wr   = req.wr_stb & (req.addr == OFS_ERR_STATUS);
  assign reply_set = SW_RECOVERY & (lresp_valid_i
                     | (lreq_sent_i & (lreq_cmd_o == CMD_NO_REPLY)));
  assign idle2_writable = IDLE2_SUPPORT & ~HIGH_RATE;

  // ***********************************************
  // link request command
  // ***********************************************
  // the go pulse follows the completing write by one cycle
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      lreq_cmd_o <= CMD_RST;
      lreq_go_o  <= 1'b0;
    end
    else if (clk_en_i)
    begin
      lreq_go_o <= lreq_wr;
      if (lreq_wr)
        lreq_cmd_o <= req.wdata[CMD_W-1:0];
    end
  end

  // ***********************************************
  // reply capture
  // ***********************************************
  // set wins over the read clear in the same cycle
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
      reply_valid <= 1'b0;
    else if (clk_en_i)
    begin
      if (reply_set)
        reply_valid <= 1'b1;
      else if (reply_rd)
        reply_valid <= 1'b0;
    end
  end

  // status fields only move on a real response symbol
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      reply_ack_index <= ACK_INDEX_RST;
      reply_port      <= PSTAT_RST;
    end
    else if (clk_en_i && SW_RECOVERY && lresp_valid_i)
    begin
      reply_ack_index <= lresp_ack_i;
      reply_port      <= lresp_port_i;
    end
  end

  // ***********************************************
  // error and status bits
  // ***********************************************
  // retry flags: hardware set beats the software clear
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      retry_enc <= 1'b0;
      retried   <= 1'b0;
    end
    else if (clk_en_i)
    begin
      if (retry_rx_i)
        retry_enc <= 1'b1;
      else if (stat_wr && req.wdata[RETRY_ENC_BIT])
        retry_enc <= 1'b0;
      if (retry_rx_i)
        retried <= 1'b1;
      else if (pa_rx_i || pna_rx_i)
        retried <= 1'b0;
    end
  end

  // idle selection holds its reset value when frozen
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
      idle2_enable_o <= IDLE2_EN_RST & IDLE2_SUPPORT;
    else if (clk_en_i && stat_wr && idle2_writable)
      idle2_enable_o <= req.wdata[IDLE2_EN_BIT];
  end

  // ***********************************************
  // read mux
  // ***********************************************
  // every bit not placed here reads as zero
  always_comb
  begin
    next_rdata = RDATA_RST;
    case (req.addr)
      OFS_LINK_REQUEST:
      begin
        if (SW_RECOVERY)
          next_rdata[CMD_W-1:0] = lreq_cmd_o;
      end
      OFS_REPLY:
      begin
        if (SW_RECOVERY)
        begin
          next_rdata[REPLY_VALID_BIT]               = reply_valid;
          next_rdata[REPLY_ACK_LSB +: IDX_W]        = reply_ack_index;
          next_rdata[REPLY_PORT_LSB +: PSTAT_W]     = reply_port;
        end
      end
      OFS_ACK_INDEX:
      begin
        if (SW_RECOVERY)
        begin
          next_rdata[FLUSH_BIT]             = 1'b0;
          next_rdata[RX_IDX_LSB +: IDX_W]    = rx_expected_o;
          next_rdata[AWAIT_IDX_LSB +: IDX_W] = tx_awaited_o;
          next_rdata[TX_IDX_LSB +: IDX_W]    = tx_next_o;
        end
      end
      OFS_ERR_STATUS:
      begin
        next_rdata[IDLE2_SUP_BIT] = IDLE2_SUPPORT;
        next_rdata[IDLE2_EN_BIT]  = idle2_enable_o;
        next_rdata[IDLE_ACT_BIT]  = idle2_active_i;
        next_rdata[FLOW_MODE_BIT] = tx_flow_ctrl_i;
        next_rdata[RETRY_ENC_BIT] = retry_enc;
        next_rdata[RETRIED_BIT]   = retried;
      end
      default:
        next_rdata = RDATA_RST;
    endcase
  end

  // ***********************************************
  // bus answer
  // ***********************************************
  // data and error are fixed at capture and held through completion
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      prdata_o  <= RDATA_RST;
      pslverr_o <= 1'b0;
    end
    else if (clk_en_i && req.acc_stb)
    begin
      prdata_o  <= req.is_write ? RDATA_RST : next_rdata;
      pslverr_o <= ~is_mapped(req.addr);
    end
  end

  // ***********************************************
  // assertions
  // ***********************************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i || !clk_en_i);

  reply_set_a: assert property (lresp_valid_i && SW_RECOVERY |=> reply_valid)
    else $error("reply valid not set by response");
  reply_clear_a: assert property (reply_rd && !reply_set ##1 !reply_set |=> !reply_valid)
    else $error("reply valid not cleared by read");
  no_reply_a: assert property (SW_RECOVERY && lreq_sent_i && lreq_cmd_o == CMD_NO_REPLY
                               |=> reply_valid)
    else $error("reply valid not set after sent request");
  reply_fields_a: assert property (SW_RECOVERY && lresp_valid_i
                                   |=> reply_ack_index == $past(lresp_ack_i)
                                       && reply_port == $past(lresp_port_i))
    else $error("reply fields not captured");
  flush_zero_a: assert property (req.acc_stb && !req.is_write && req.addr == OFS_ACK_INDEX
                                 |=> !prdata_o[FLUSH_BIT])
    else $error("flush bit read as one");
  flush_pulse_a: assert property (SW_RECOVERY && req.wr_stb && req.addr == OFS_ACK_INDEX
                                  && req.wdata[FLUSH_BIT] |=> flush_acks_o)
    else $error("flush command missing");
  rx_locked_a: assert property (req.wr_stb && req.addr == OFS_ACK_INDEX
                                && req.wdata[FLUSH_BIT] && !rx_pkt_acked_i
                                |=> $stable(rx_expected_o))
    else $error("inbound index written with flush set");
  tx_load_a: assert property (SW_RECOVERY && req.wr_stb && req.addr == OFS_ACK_INDEX
                              |=> tx_next_o == $past(req.wdata[5:0]) && retransmit_o)
    else $error("outbound index write not applied");
  retry_latch_a: assert property (retry_rx_i |=> retry_enc && retried)
    else $error("retry flags not set");
  retry_clear_a: assert property ((pa_rx_i || pna_rx_i) && !retry_rx_i |=> !retried)
    else $error("retried not cleared by accept");
  lreq_send_a: assert property (SW_RECOVERY && req.wr_stb && req.addr == OFS_LINK_REQUEST
                                |=> lreq_go_o && lreq_cmd_o == $past(req.wdata[2:0])
                                    ##1 !lreq_go_o)
    else $error("link request not issued");
  ready_pulse_a: assert property (req.acc_stb |=> pready_o ##1 !pready_o)
    else $error("ready not a single cycle");

  reply_read_c: cover property (reply_valid ##1 reply_rd ##1 !reply_valid);
  flush_write_c: cover property (flush_acks_o);
  retry_w1c_c: cover property (retry_enc && stat_wr && req.wdata[RETRY_ENC_BIT]);
  unmapped_c: cover property (req.acc_stb && !is_mapped(req.addr));

endmodule // rio_error_recovery_csrs
`default_nettype wire

// file: verif/link_partner_model.sv
// link partner stand-in answering link requests
`timescale 1ns/10ps
`default_nettype none
module link_partner_model
#(
  parameter logic [5:0] RESP_ACK  = 6'h2A,  // ack index in replies
  parameter logic [4:0] RESP_PORT = 5'h15   // port status in replies
)(
  input  wire logic       ref_clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       lreq_go_i,
  input  wire logic [2:0] lreq_cmd_i,
  output var  logic       lreq_sent_o,
  output var  logic       lresp_valid_o,
  output var  logic [5:0] lresp_ack_o,
  output var  logic [4:0] lresp_port_o
);
  logic [3:0] stage;  // request out, reply back
  // shift each request through the lane
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
      stage <= 4'h0;
    else
      stage <= {stage[2:0], lreq_go_i};
  end
  assign lreq_sent_o   = stage[1];
  assign lresp_valid_o = stage[3] && (lreq_cmd_i != 3'h3);
  // fields stray outside a reply so stale data is never trusted
  assign lresp_ack_o   = lresp_valid_o ? RESP_ACK : ~RESP_ACK;
  assign lresp_port_o  = lresp_valid_o ? RESP_PORT : ~RESP_PORT;
endmodule // link_partner_model
`default_nettype wire

// file: verif/tb_rio_error_recovery_csrs.sv
// self-checking bench for the error recovery registers
`timescale 1ns/10ps
`default_nettype none
module tb_rio_error_recovery_csrs;
  import rio_csr_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [7:0]  padr = 8'h00;
  logic [31:0] pwd = 32'h0, prd, rdat;
  logic        prdy, perr, serr, go, sent, rv;
  logic        perr0, serr0, flush, retx, idl;
  logic [31:0] prd0, rdat0;
  logic [2:0]  cmd;
  logic [5:0]  rack;
  logic [4:0]  rport;
  logic [4:0]  ev = 5'h00;  // retry, accept, reject, rx acked, tx sent
  ack_index_t  rxe, txa, txn;
  int          mismatches = 0;
  int          comparisons = 0;
  int          nflush = 0, nretx = 0;  // command pulses seen
  always #50 clk = ~clk;
  rio_error_recovery_csrs DUT (.ref_clk_i(clk), .sys_rst_i(rst), .clk_en_i(1'b1),
    .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(padr), .pwdata_i(pwd),
    .prdata_o(prd), .pready_o(prdy), .pslverr_o(perr), .lresp_valid_i(rv),
    .lresp_ack_i(rack), .lresp_port_i(rport), .lreq_sent_i(sent), .rx_pkt_acked_i(ev[1]),
    .tx_pkt_sent_i(ev[0]), .pa_rx_i(ev[3]), .pna_rx_i(ev[2]), .retry_rx_i(ev[4]),
    .idle2_active_i(1'b1), .tx_flow_ctrl_i(1'b1), .lreq_cmd_o(cmd), .lreq_go_o(go),
    .flush_acks_o(flush), .retransmit_o(retx), .rx_expected_o(rxe), .tx_awaited_o(txa),
    .tx_next_o(txn), .idle2_enable_o(idl));
  // second copy built without recovery and without the second idle
  rio_error_recovery_csrs #(.SW_RECOVERY(1'b0), .IDLE2_SUPPORT(1'b0)) DUT0 (.ref_clk_i(clk),
    .sys_rst_i(rst), .clk_en_i(1'b1), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(padr), .pwdata_i(pwd), .prdata_o(prd0), .pready_o(), .pslverr_o(perr0),
    .lresp_valid_i(rv), .lresp_ack_i(rack), .lresp_port_i(rport), .lreq_sent_i(sent),
    .rx_pkt_acked_i(ev[1]), .tx_pkt_sent_i(ev[0]), .pa_rx_i(ev[3]), .pna_rx_i(ev[2]),
    .retry_rx_i(ev[4]), .idle2_active_i(1'b1), .tx_flow_ctrl_i(1'b1), .lreq_cmd_o(),
    .lreq_go_o(), .flush_acks_o(), .retransmit_o(), .rx_expected_o(), .tx_awaited_o(),
    .tx_next_o(), .idle2_enable_o());
  // count one-cycle command pulses, they pass while a transfer is closing
  always @(posedge clk)
  begin
    nflush <= nflush + flush;
    nretx  <= nretx + retx;
  end
  link_partner_model partner (.ref_clk_i(clk), .sys_rst_i(rst), .lreq_go_i(go),
    .lreq_cmd_i(cmd), .lreq_sent_o(sent), .lresp_valid_o(rv), .lresp_ack_o(rack),
    .lresp_port_o(rport));
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one apb transfer, request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwr  <= w;
    padr <= a;
    pwd  <= d;
    @(posedge clk);
    pen <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (prdy !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      check(1'b0, 1'b1);
      give_verdict();
    end
    rdat = prd;
    serr = perr;
    rdat0 = prd0;
    serr0 = perr0;
    psel <= 1'b0;
    pen  <= 1'b0;
    @(posedge clk);
  endtask
  task automatic pulse(input logic [4:0] v);
    ev <= v;
    @(posedge clk);
    ev <= 5'h00;
    repeat (2) @(posedge clk);
  endtask
  // reset values, then two requests with reply and one without
  task automatic t_link();
    apb(1'b0, OFS_REPLY, 32'h0);
    check(rdat, 32'h0);
    check({serr0, rdat0}, 33'h1_0000_0000);
    apb(1'b0, OFS_ERR_STATUS, 32'h0);
    check(rdat, 32'hA800_0000);
    repeat (2) apb(1'b1, OFS_LINK_REQUEST, 32'hFFFF_FFFA);
    check(cmd, 3'h2);
    repeat (6) @(posedge clk);  // let the second reply land before reading
    apb(1'b0, OFS_REPLY, 32'h0);
    check(rdat, 32'h8000_0555);
    apb(1'b0, OFS_REPLY, 32'h0);
    check(rdat, 32'h0000_0555);
    apb(1'b1, OFS_LINK_REQUEST, 32'h3);
    repeat (6) @(posedge clk);
    apb(1'b0, OFS_REPLY, 32'h0);
    check(rdat, 32'h8000_0555);
    apb(1'b0, 8'h4C, 32'h0);
    check({serr, rdat}, 33'h1_0000_0000);
    $display("test link done");
  endtask
  // index writes, flush guard and hardware steps
  task automatic t_index();
    apb(1'b1, OFS_ACK_INDEX, 32'h7F00_FFFF);
    apb(1'b0, OFS_ACK_INDEX, 32'h0);
    check(rdat, 32'h3F00_003F);
    apb(1'b1, OFS_ACK_INDEX, 32'h8500_0005);
    apb(1'b0, OFS_ACK_INDEX, 32'h0);
    check(rdat, 32'h3F00_0005);
    check(nflush, 32'h1);
    check(nretx, 32'h2);
    pulse(5'h0B);
    check({rxe, txa, txn}, 18'h00046);
    $display("test index done");
  endtask
  // retry flags and idle selection
  task automatic t_status();
    pulse(5'h10);
    apb(1'b0, OFS_ERR_STATUS, 32'h0);
    check(rdat, 32'hA818_0000);
    apb(1'b1, OFS_ERR_STATUS, 32'h4010_0000);
    apb(1'b0, OFS_ERR_STATUS, 32'h0);
    check(rdat, 32'hE808_0000);
    check(idl, 1'b1);
    check({serr0, rdat0}, 33'h0_2808_0000);
    pulse(5'h04);
    apb(1'b0, OFS_ERR_STATUS, 32'h0);
    check(rdat, 32'hE800_0000);
    $display("test status done");
  endtask
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_link();
    t_index();
    t_status();
    give_verdict();
  end
endmodule // tb_rio_error_recovery_csrs
`default_nettype wire
